/* File: include/deac_pkg.sv */
// Package for the data EEPROM access control block.
// Assumes a single core clock and an SFR byte bus from the CPU core.
package deac_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] MEM_CTRL_ADDR     = 8'h96; // eeprom_memory_control
   localparam logic [7:0] PTR0_LO_ADDR      = 8'h82;
   localparam logic [7:0] PTR0_HI_ADDR      = 8'h83;
   localparam logic [7:0] PTR1_LO_ADDR      = 8'h84;
   localparam logic [7:0] PTR1_HI_ADDR      = 8'h85;
   localparam logic [7:0] MEM_CTRL_RESET    = 8'h03; // Ready and no inhibit
   localparam logic [7:0] MEM_CTRL_SW_MASK  = 8'h3c; // Bits software may write
   // ==========================================================
   // Field positions
   localparam int BIT_PAGE_LOAD   = 5;
   localparam int BIT_WRITE_EN    = 4;
   localparam int BIT_INT_SELECT  = 3;
   localparam int BIT_BANK_SELECT = 2;
   localparam int BIT_READY       = 1;
   localparam int BIT_INHIBIT     = 0;
   // ==========================================================
   // Array geometry and timing
   localparam int EE_ADDR_W      = 11;             // 2K bytes
   localparam int PAGE_BYTES     = 32;
   localparam int PAGE_OFS_W     = 5;
   localparam int CLK_MHZ        = 100;
   localparam int PROG_TIME_MS   = 4;
   localparam int PROG_CYCLES    = PROG_TIME_MS * 1000 * CLK_MHZ;
   // ==========================================================
   // CPU move request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  data;
   } deac_move_t;
   typedef enum {DEAC_IDLE, DEAC_PROG} deac_state_t;
endpackage : deac_pkg

/* File: src/deac_sync.sv */
// Three-stage synchroniser for an asynchronous level.
// Assumes the input may change at any time against core_clk.
`timescale 1ns/1ps
module deac_sync (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // Level in and filtered level out
   input  wire logic async_in,
   output logic      level_out
);
   logic s1_r, s2_r, s3_r;
   // ==========================================================
   // Chain; output follows only when stages two and three agree
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r      <= 1'b0;
         s2_r      <= 1'b0;
         s3_r      <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_out <= s3_r;
         end
      end
   end
endmodule : deac_sync

/* File: src/deac_timer.sv */
// Self-timed programming cycle counter.
// Assumes start and abort are single-cycle pulses on core_clk.
`timescale 1ns/1ps
module deac_timer #(
   parameter int CYCLES = deac_pkg::PROG_CYCLES
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // Control
   input  wire logic start,
   input  wire logic abort,
   // Status
   output logic      done
);
   logic [31:0] cnt_r;
   // ==========================================================
   // Counts down; done pulses on the last cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 32'h0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            cnt_r <= 32'h0;
         end else if (start) begin
            cnt_r <= 32'(CYCLES);
         end else if (cnt_r != 32'h0) begin
            cnt_r <= cnt_r - 32'h1;
            done  <= (cnt_r == 32'h1);
         end
      end
   end
endmodule : deac_timer

/* File: src/deac_top.sv */
// Data EEPROM access control: memory control register, pointer banks,
// page buffer, 2K array and self-timed programming.
// Assumes the CPU core presents SFR accesses and data-memory moves as
// one-cycle requests on core_clk; low_supply_n arrives asynchronously.
`timescale 1ns/1ps
module deac_top #(
   parameter int PROG_CYCLES = deac_pkg::PROG_CYCLES
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   // SFR byte bus
   input  wire logic               sfr_wr,
   input  wire logic               sfr_rd,
   input  wire logic [7:0]         sfr_addr,
   input  wire logic [7:0]         sfr_wdata,
   output logic      [7:0]         sfr_rdata,
   output logic                    sfr_hit,
   // Data-memory move request through the data pointer
   input  wire deac_pkg::deac_move_t move_req,
   output logic      [7:0]         move_rdata,
   output logic                    move_rvalid,
   // External data memory
   output logic                    ext_req,
   output logic                    ext_wr,
   output logic      [15:0]        ext_addr,
   output logic      [7:0]         ext_wdata,
   // Active pointer and supply status
   output logic      [15:0]        data_pointer,
   input  wire logic               low_supply_n
);
   localparam int AW = deac_pkg::EE_ADDR_W;
   localparam int PW = deac_pkg::PAGE_OFS_W;

   logic [7:0]  ctrl_r;
   logic [15:0] ptr0_r, ptr1_r;
   logic [7:0]  array_r [0:(1<<AW)-1];
   logic [7:0]  buf_r   [0:deac_pkg::PAGE_BYTES-1];
   logic [deac_pkg::PAGE_BYTES-1:0] buf_vld_r;
   logic [AW-1:0] prog_addr_r;
   logic [7:0]    prog_data_r;
   logic [AW-PW-1:0] prog_page_r;
   deac_pkg::deac_state_t state_r;
   logic supply_ok, prog_done, is_ee, ee_wr, start, abort;
   logic [AW-1:0] ee_addr;

   // ==========================================================
   // Supply detect synchroniser and timer
   deac_sync u_sync (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .async_in  (low_supply_n),
      .level_out (supply_ok)
   );
   deac_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .start    (start),
      .abort    (abort),
      .done     (prog_done)
   );

   // ==========================================================
   // Move decode
   assign ee_addr = move_req.addr[AW-1:0];
   assign is_ee   = ctrl_r[deac_pkg::BIT_INT_SELECT] && (move_req.addr[15:AW] == '0);
   // Writes only reach the array path with write enable set and idle
   // Writes while busy are dropped whole: buffering them would mix two pages
   assign ee_wr   = move_req.valid && move_req.write && is_ee &&
                    ctrl_r[deac_pkg::BIT_WRITE_EN] && (state_r == deac_pkg::DEAC_IDLE);
   // Final write with page-load clear starts a cycle unless inhibited
   assign start   = ee_wr && !ctrl_r[deac_pkg::BIT_PAGE_LOAD] && supply_ok;
   assign abort   = (state_r == deac_pkg::DEAC_PROG) && !supply_ok;

   // ==========================================================
   // Control register; status bits are hardware-only
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= deac_pkg::MEM_CTRL_RESET;
      end else begin
         if (sfr_wr && sfr_addr == deac_pkg::MEM_CTRL_ADDR) begin
            ctrl_r[5:2] <= sfr_wdata[5:2];
         end
         ctrl_r[7:6] <= 2'b00;
         // Ready low from the cycle after the starting move and high again on
         // completion or abort; a read in the same cycle as that move still sees
         // one, which software must not take as done
         ctrl_r[deac_pkg::BIT_READY] <= (state_r == deac_pkg::DEAC_IDLE) ? !start
                                        : (prog_done || abort);
         ctrl_r[deac_pkg::BIT_INHIBIT] <= supply_ok;
      end
   end

   // ==========================================================
   // Pointer banks
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr0_r <= 16'h0000;
         ptr1_r <= 16'h0000;
      end else if (sfr_wr) begin
         if (sfr_addr == deac_pkg::PTR0_LO_ADDR) begin
            ptr0_r[7:0] <= sfr_wdata;
         end else if (sfr_addr == deac_pkg::PTR0_HI_ADDR) begin
            ptr0_r[15:8] <= sfr_wdata;
         end else if (sfr_addr == deac_pkg::PTR1_LO_ADDR) begin
            ptr1_r[7:0] <= sfr_wdata;
         end else if (sfr_addr == deac_pkg::PTR1_HI_ADDR) begin
            ptr1_r[15:8] <= sfr_wdata;
         end
      end
   end

   // Active pointer output registered from the bank select
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_pointer <= 16'h0000;
      end else begin
         data_pointer <= ctrl_r[deac_pkg::BIT_BANK_SELECT] ? ptr1_r : ptr0_r;
      end
   end

   // ==========================================================
   // SFR read port; unmapped addresses give no hit and zero
   // Data stand one cycle only, then fall back to zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
         sfr_hit   <= 1'b0;
      end else begin
         sfr_hit   <= 1'b0;
         sfr_rdata <= 8'h00;
         if (sfr_rd) begin
            if (sfr_addr == deac_pkg::MEM_CTRL_ADDR) begin
               sfr_rdata <= {2'b00, ctrl_r[5:0]};
               sfr_hit   <= 1'b1;
            end else if (sfr_addr == deac_pkg::PTR0_LO_ADDR) begin
               sfr_rdata <= ptr0_r[7:0];
               sfr_hit   <= 1'b1;
            end else if (sfr_addr == deac_pkg::PTR0_HI_ADDR) begin
               sfr_rdata <= ptr0_r[15:8];
               sfr_hit   <= 1'b1;
            end else if (sfr_addr == deac_pkg::PTR1_LO_ADDR) begin
               sfr_rdata <= ptr1_r[7:0];
               sfr_hit   <= 1'b1;
            end else if (sfr_addr == deac_pkg::PTR1_HI_ADDR) begin
               sfr_rdata <= ptr1_r[15:8];
               sfr_hit   <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Programming state; aborted cycles leave the array untouched
   // Completion and abort both return to idle; the timer clears itself on abort
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r     <= deac_pkg::DEAC_IDLE;
         prog_addr_r <= '0;
         prog_data_r <= 8'h00;
         prog_page_r <= '0;
      end else begin
         case (state_r)
            deac_pkg::DEAC_IDLE: begin
               if (start) begin
                  state_r     <= deac_pkg::DEAC_PROG;
                  prog_addr_r <= ee_addr;
                  prog_data_r <= move_req.data;
                  prog_page_r <= ee_addr[AW-1:PW];
               end
            end
            deac_pkg::DEAC_PROG: begin
               if (prog_done || abort) begin
                  state_r <= deac_pkg::DEAC_IDLE;
               end
            end
            default: state_r <= deac_pkg::DEAC_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Page buffer: loads byte; final write joins the page
   // Refused writes may change buffer data but never its valid bits
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_vld_r <= '0;
      end else if (ee_wr && (start || ctrl_r[deac_pkg::BIT_PAGE_LOAD])) begin
         buf_vld_r[ee_addr[PW-1:0]] <= 1'b1;
      end else if (state_r == deac_pkg::DEAC_PROG && (prog_done || abort)) begin
         buf_vld_r <= '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (ee_wr) begin
         buf_r[ee_addr[PW-1:0]] <= move_req.data;
      end
   end

   // Loaded bytes of the page committed at once when the cycle completes
   // The array has no reset, so a never-written location reads as unknown
   always_ff @(posedge core_clk) begin
      if (state_r == deac_pkg::DEAC_PROG && prog_done && !abort) begin
         for (int i = 0; i < deac_pkg::PAGE_BYTES; i++) begin
            if (buf_vld_r[i]) begin
               array_r[{prog_page_r, PW'(i)}] <= buf_r[i];
            end
         end
      end
   end

   // ==========================================================
   // Move answers and external routing
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         move_rdata  <= 8'h00;
         move_rvalid <= 1'b0;
         ext_req     <= 1'b0;
         ext_wr      <= 1'b0;
         ext_addr    <= 16'h0000;
         ext_wdata   <= 8'h00;
      end else begin
         move_rvalid <= move_req.valid && !move_req.write && is_ee;
         ext_req     <= move_req.valid && !is_ee;
         ext_wr      <= move_req.valid && move_req.write && !is_ee;
         ext_addr    <= move_req.addr;
         ext_wdata   <= move_req.data;
         if (move_req.valid && !move_req.write && is_ee) begin
            if (state_r == deac_pkg::DEAC_PROG) begin
               move_rdata <= {~prog_data_r[7], prog_data_r[6:0]};
            end else begin
               move_rdata <= array_r[ee_addr];
            end
         end
      end
   end

   // ==========================================================
   // Checks
   chk_ready_low_prog: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == deac_pkg::DEAC_PROG) |=> !ctrl_r[deac_pkg::BIT_READY] || state_r == deac_pkg::DEAC_IDLE)
      else $error("ready high during programming");
   chk_ready_after_done: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == deac_pkg::DEAC_PROG && prog_done) |=> ctrl_r[deac_pkg::BIT_READY])
      else $error("ready not restored");
   chk_ready_drop_late: assert property (@(posedge core_clk) disable iff (!rst_b)
      start |-> ctrl_r[deac_pkg::BIT_READY] ##1 !ctrl_r[deac_pkg::BIT_READY])
      else $error("ready timing wrong");
   chk_load_no_prog: assert property (@(posedge core_clk) disable iff (!rst_b)
      (ee_wr && ctrl_r[deac_pkg::BIT_PAGE_LOAD]) |=> state_r == deac_pkg::DEAC_IDLE)
      else $error("page load started programming");
   chk_inhibit_abort: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == deac_pkg::DEAC_PROG && !supply_ok) |=> state_r == deac_pkg::DEAC_IDLE)
      else $error("programming not aborted");
   chk_inhibit_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      !supply_ok |=> !ctrl_r[deac_pkg::BIT_INHIBIT])
      else $error("inhibit flag not cleared");
   chk_wen_guard: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == deac_pkg::DEAC_IDLE && !ctrl_r[deac_pkg::BIT_WRITE_EN]) |=> state_r == deac_pkg::DEAC_IDLE)
      else $error("programming without write enable");
   chk_ext_route: assert property (@(posedge core_clk) disable iff (!rst_b)
      (move_req.valid && move_req.addr[15:AW] != '0) |=> ext_req)
      else $error("high address not external");
   chk_unused_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 ctrl_r[7:6] == 2'b00)
      else $error("unused bits set");
   chk_msb_invert: assert property (@(posedge core_clk) disable iff (!rst_b)
      (move_req.valid && !move_req.write && is_ee && state_r == deac_pkg::DEAC_PROG)
      |=> move_rdata[7] != prog_data_r[7])
      else $error("busy read not inverted");

   // ==========================================================
   // Routing, pointer selection and flag ownership
   chk_route_eeprom: assert property (@(posedge core_clk) disable iff (!rst_b)
      (move_req.valid && !move_req.write && is_ee) |=> move_rvalid && !ext_req)
      else $error("eeprom read routed external");
   chk_bank_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 data_pointer == ($past(ctrl_r[deac_pkg::BIT_BANK_SELECT]) ? $past(ptr1_r) : $past(ptr0_r)))
      else $error("active pointer not from selected bank");
   chk_start_prog: assert property (@(posedge core_clk) disable iff (!rst_b)
      start |=> state_r == deac_pkg::DEAC_PROG)
      else $error("final write did not start programming");
   chk_flags_hw_only: assert property (@(posedge core_clk) disable iff (!rst_b)
      (sfr_wr && sfr_addr == deac_pkg::MEM_CTRL_ADDR) |=> ctrl_r[deac_pkg::BIT_INHIBIT] == $past(supply_ok))
      else $error("inhibit flag taken from software");
endmodule : deac_top

/* File: bench/deac_cpu_model.sv */
// CPU core model: issues SFR accesses and data-memory moves.
// Assumes deac_top takes requests on the rising edge of core_clk.
`timescale 1ns/1ps
module deac_cpu_model (
   // Clock
   input  wire logic            core_clk,
   // SFR bus
   output logic                 sfr_wr,
   output logic                 sfr_rd,
   output logic [7:0]           sfr_addr,
   output logic [7:0]           sfr_wdata,
   input  wire logic [7:0]      sfr_rdata,
   input  wire logic            sfr_hit,
   // Moves through the data pointer
   output deac_pkg::deac_move_t move_req,
   input  wire logic [7:0]      move_rdata,
   input  wire logic            move_rvalid
);
   // =========================================
   // Idle bus at time zero
   initial begin
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      move_req = '0;
   end
   // One SFR access; released address and data lines show inverted values so stale data never looks valid
   task automatic sfr_op(input logic w, input logic [7:0] a, d, output logic [7:0] q, output logic h);
      @(posedge core_clk);
      #1;
      sfr_wr = w;
      sfr_rd = ~w;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_addr <= ~a;
      sfr_wdata <= ~d;
      #1;
      q = sfr_rdata;
      h = sfr_hit;
   endtask : sfr_op
   // One data-memory move, one-cycle valid pulse
   task automatic move_op(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                          output logic v);
      @(posedge core_clk);
      #1;
      move_req = '{1'b1, w, a, d};
      @(posedge core_clk);
      move_req <= '{1'b0, ~w, ~a, ~d};
      #1;
      q = move_rdata;
      v = move_rvalid;
   endtask : move_op
endmodule : deac_cpu_model

/* File: bench/deac_top_tb.sv */
// Testbench for deac_top: register, routing, byte, page and low-supply tests.
// Assumes deac_cpu_model drives all requests; programming shortened to 20 cycles.
`timescale 1ns/1ps
module deac_top_tb;
   localparam int         PROG = 20;
   localparam logic [7:0] CTRL = deac_pkg::MEM_CTRL_ADDR;
   logic                  core_clk, rst_b, low_supply_n, sfr_wr, sfr_rd, sfr_hit, h, v;
   logic                  move_rvalid, ext_req, ext_wr;
   logic [7:0]            sfr_addr, sfr_wdata, sfr_rdata, move_rdata, ext_wdata, q;
   logic [15:0]           ext_addr, data_pointer;
   deac_pkg::deac_move_t  move_req;
   int                    failures, checks, n;
   logic [7:0]            ptr[4] = '{8'h34, 8'h12, 8'h00, 8'h08};
   logic [7:0]            rt_ctrl[3] = '{8'h08, 8'h08, 8'h00};
   logic [15:0]           rt_addr[3] = '{16'h0800, 16'h07ff, 16'h0010};
   logic [7:0]            rt_exp[3] = '{8'h02, 8'h01, 8'h02};
   // =========================================
   // Design and core model
   deac_top #(.PROG_CYCLES(PROG)) i_deac_top (.core_clk(core_clk), .rst_b(rst_b), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .move_req(move_req), .move_rdata(move_rdata), .move_rvalid(move_rvalid), .ext_req(ext_req),
      .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .data_pointer(data_pointer),
      .low_supply_n(low_supply_n));
   deac_cpu_model i_deac_cpu_model (.core_clk(core_clk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .move_req(move_req), .move_rdata(move_rdata), .move_rvalid(move_rvalid));
   // =========================================
   // Helpers
   task automatic check(input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task automatic wr(input logic [7:0] a, d);
      i_deac_cpu_model.sfr_op(1'b1, a, d, q, h);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      i_deac_cpu_model.sfr_op(1'b0, a, 8'h00, q, h);
   endtask : rd
   task automatic mv(input logic w, input logic [15:0] a, input logic [7:0] d);
      i_deac_cpu_model.move_op(w, a, d, q, v);
   endtask : mv
   // Poll the ready flag, bounded so a stuck cycle ends the run
   task automatic wait_ready;
      n = 0;
      rd(CTRL);
      while (q[1] !== 1'b1 && n < 12) begin
         rd(CTRL);
         n++;
      end
      check(q & 8'h02, 8'h02);
      if (n == 12) begin
         finish_test();
      end
   endtask : wait_ready
   // =========================================
   // Clock and hang guard
   always #5 core_clk = ~core_clk;
   initial begin
      #200000;
      failures++;
      finish_test();
   end
   // =========================================
   // Test sequence
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      low_supply_n = 1'b1;
      failures = 0;
      checks = 0;
      repeat (16) @(posedge core_clk);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge core_clk);
      rd(CTRL);
      check(q, 8'h03);
      check({7'h00, h}, 8'h01);
      wr(CTRL, 8'hff);
      rd(CTRL);
      check(q, 8'h3f);
      rd(8'h97);
      check({q[6:0], h}, 8'h00);
      $display("test register done");
      for (int i = 0; i < 4; i++) wr(8'h82 + 8'(i), ptr[i]);
      wr(CTRL, 8'h00);
      rd(CTRL);
      check(data_pointer[15:8], 8'h12);
      check(data_pointer[7:0], 8'h34);
      wr(CTRL, 8'h04);
      rd(8'h85);
      check(q, 8'h08);
      check(data_pointer[15:8], 8'h08);
      $display("test pointer done");
      // Routing table: eeprom select and the 2K boundary
      for (int i = 0; i < 3; i++) begin
         wr(CTRL, rt_ctrl[i]);
         mv(1'b0, rt_addr[i], 8'h00);
         check({6'h00, ext_req, v}, rt_exp[i]);
      end
      mv(1'b1, 16'h0800, 8'h77);
      check({ext_wr, ext_addr[13:8], ext_wdata[0]}, 8'h91);
      check(ext_wdata, 8'h77);
      check(ext_addr[7:0], 8'h00);
      wr(CTRL, 8'h08);
      mv(1'b1, 16'h0010, 8'h55);
      rd(CTRL);
      check(q, 8'h0b);
      $display("test routing done");
      // Byte write, busy read, completion
      wr(CTRL, 8'h18);
      mv(1'b1, 16'h0010, 8'ha5);
      rd(CTRL);
      check(q & 8'h02, 8'h00);
      mv(1'b0, 16'h0010, 8'h00);
      check(q, 8'h25);
      repeat (PROG - 10) @(posedge core_clk);
      rd(CTRL);
      check(q & 8'h02, 8'h00);
      wait_ready();
      mv(1'b0, 16'h0010, 8'h00);
      check(q, 8'ha5);
      $display("test byte done");
      // Page load then final write in the same page
      wr(CTRL, 8'h38);
      for (int i = 0; i < 4; i++) mv(1'b1, 16'h0040 + 16'(i), 8'hc0 + 8'(i));
      rd(CTRL);
      check(q & 8'h02, 8'h02);
      wr(CTRL, 8'h18);
      mv(1'b1, 16'h0044, 8'hc4);
      rd(CTRL);
      check(q & 8'h02, 8'h00);
      wait_ready();
      for (int i = 0; i < 5; i++) begin
         mv(1'b0, 16'h0040 + 16'(i), 8'h00);
         check(q, 8'hc0 + 8'(i));
      end
      $display("test page done");
      // Low supply aborts a cycle and blocks new ones
      mv(1'b1, 16'h0010, 8'h5a);
      low_supply_n = 1'b0;
      repeat (8) @(posedge core_clk);
      rd(CTRL);
      check(q, 8'h1a);
      mv(1'b1, 16'h0010, 8'h66);
      rd(CTRL);
      check(q, 8'h1a);
      mv(1'b0, 16'h0010, 8'h00);
      check(q, 8'ha5);
      low_supply_n = 1'b1;
      repeat (8) @(posedge core_clk);
      rd(CTRL);
      check(q, 8'h1b);
      wr(CTRL, 8'h00);
      $display("test supply done");
      finish_test();
   end
endmodule : deac_top_tb
